/* core/dap_top.sv */
// Sleep-mode control and CMOS / DDR LVDS output port of a dual converter.
// Assumes an AXI4-Lite master on aclk and samples that change with samp_clk_pin.
`timescale 1ns/1ps
`default_nettype none
module dap_top #(
    parameter int SAMPLE_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic samp_clk_pin,
    input wire logic mode_pin_msb,
    input wire logic mode_pin_mid,
    input wire logic mode_pin_lsb,
    input wire logic interface_select_pin,
    input wire logic [SAMPLE_W-1:0] conv_a_sample,
    input wire logic [SAMPLE_W-1:0] conv_b_sample,
    output logic [SAMPLE_W-1:0] chan_a_bus_o,
    output logic chan_a_bus_oe,
    output logic [SAMPLE_W-1:0] chan_b_bus_o,
    output logic chan_b_bus_oe,
    output logic [SAMPLE_W/2-1:0] lvds_a_o,
    output logic lvds_a_oe,
    output logic [SAMPLE_W/2-1:0] lvds_b_o,
    output logic lvds_b_oe,
    output logic output_clock_single,
    output logic output_clock_single_oe,
    output logic output_clock_pos,
    output logic output_clock_pos_oe,
    output logic data_drive_level,
    output logic clock_drive_level,
    output logic conv_a_power_en,
    output logic conv_b_power_en,
    output logic ref_power_en,
    output logic low_power
);
    localparam int PAIRS = SAMPLE_W / 2;

    // Pair mapping is fixed to the documented word width
    if (SAMPLE_W != dap_pkg::SAMPLE_BITS || SAMPLE_W % 2 != 0)
    begin : g_bad_width
        $error("SAMPLE_W must be 12");
    end

    // ============================================================
    // Input synchronisers
    dap_pkg::dap_pins_t sync1_reg, sync2_reg, pins_in;
    logic samp_d_reg;

    assign pins_in = '{samp_clk_pin, mode_pin_msb, mode_pin_mid, mode_pin_lsb,
                       interface_select_pin, conv_a_sample, conv_b_sample};

    // Two stages; only the second stage feeds logic
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            samp_d_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            samp_d_reg <= sync2_reg.samp;
        end
    end

    logic samp_rise, samp_fall;
    assign samp_rise = sync2_reg.samp && !samp_d_reg;
    assign samp_fall = !sync2_reg.samp && samp_d_reg;

    // ============================================================
    // Register bus slave
    dap_pkg::dap_ctrl_t ctrl_reg, ctrl_next;
    logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic [11:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic w_strb0_reg, w_strb0_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next, status_word;
    logic aw_have, w_have, do_wr;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_strb0;

    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // Address and data may arrive in either order; each is parked until both are here
    always_comb
    begin
        aw_have = aw_full_reg || (s_axi_awvalid && s_axi_awready);
        w_have = w_full_reg || (s_axi_wvalid && s_axi_wready);
        do_wr = aw_have && w_have;
        wr_addr = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
        wr_data = w_full_reg ? w_data_reg : s_axi_wdata;
        wr_strb0 = w_full_reg ? w_strb0_reg : s_axi_wstrb[0];
        aw_full_next = aw_have && !do_wr;
        w_full_next = w_have && !do_wr;
        aw_addr_next = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
        w_data_next = w_full_reg ? w_data_reg : s_axi_wdata;
        w_strb0_next = w_full_reg ? w_strb0_reg : s_axi_wstrb[0];
        ctrl_next = ctrl_reg;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        if (do_wr)
        begin
            bvalid_next = 1'b1;
            bresp_next = dap_pkg::RESP_OKAY;
            if (wr_addr[11:2] == dap_pkg::CTRL_OFF[11:2])
            begin
                if (wr_strb0)
                    ctrl_next = wr_data[dap_pkg::CTRL_W-1:0];
            end
            else if (wr_addr[11:2] != dap_pkg::STAT_OFF[11:2])
                bresp_next = dap_pkg::RESP_SLVERR;
        end
        rvalid_next = rvalid_reg && !s_axi_rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rresp_next = dap_pkg::RESP_OKAY;
            if (s_axi_araddr[11:2] == dap_pkg::CTRL_OFF[11:2])
                rdata_next = {25'h0, ctrl_reg};
            else if (s_axi_araddr[11:2] == dap_pkg::STAT_OFF[11:2])
                rdata_next = status_word;
            else
            begin
                rdata_next = 32'h00000000;
                rresp_next = dap_pkg::RESP_SLVERR;
            end
        end
    end

    // Bus state registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= dap_pkg::CTRL_RESET;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h00000000;
            w_strb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb0_reg <= w_strb0_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // ============================================================
    // Mode decode and power control
    dap_pkg::dap_mode_t mode;
    logic lvds_on, mux_on, clk_stopped, gpd;
    logic [7:0] stop_cnt_reg, stop_cnt_next;
    logic [1:0] conv_on, buf_on, chan_valid;
    logic [dap_pkg::WAKE_W-1:0] wake_reg [2];
    logic [dap_pkg::WAKE_W-1:0] wake_next [2];

    // Pin source puts the msb pin on bit 2
    assign mode = dap_pkg::dap_mode_t'(ctrl_reg.pin_config ?
        {sync2_reg.mode_pin_msb, sync2_reg.mode_pin_mid, sync2_reg.mode_pin_lsb} :
        ctrl_reg.sleep_code);
    assign lvds_on = ctrl_reg.pin_config ? sync2_reg.interface_select_pin
                                         : ctrl_reg.lvds_sel;
    // Mux code under LVDS falls back to both channels active
    assign mux_on = (mode == dap_pkg::DAP_MUX) && !lvds_on;
    assign clk_stopped = stop_cnt_reg >= dap_pkg::STOP_LIM;
    assign gpd = (mode == dap_pkg::DAP_PWRDN) || clk_stopped;

    // Power and buffer enables per mode, wake timers count from enable
    always_comb
    begin
        stop_cnt_next = samp_rise ? 8'h00 :
            (clk_stopped ? stop_cnt_reg : stop_cnt_reg + 8'h01);
        conv_on[0] = !gpd && (mode != dap_pkg::DAP_STBY_A);
        conv_on[1] = !gpd && (mode != dap_pkg::DAP_STBY_B);
        buf_on[0] = conv_on[0] && mode != dap_pkg::DAP_OFF_A
            && mode != dap_pkg::DAP_OFF_AB && !mux_on;
        buf_on[1] = conv_on[1] && mode != dap_pkg::DAP_OFF_B
            && mode != dap_pkg::DAP_OFF_AB;
        for (int c = 0; c < 2; c++)
        begin
            if (gpd)
                wake_next[c] = dap_pkg::GPD_WAKE_LD;
            else if (!buf_on[c])
                wake_next[c] = (wake_reg[c] > dap_pkg::FAST_WAKE_LD) ?
                    wake_reg[c] : dap_pkg::FAST_WAKE_LD;
            else if (wake_reg[c] != '0)
                wake_next[c] = wake_reg[c] - 1'b1;
            else
                wake_next[c] = wake_reg[c];
            chan_valid[c] = buf_on[c] && (wake_reg[c] == '0);
        end
    end

    // Power state registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stop_cnt_reg <= 8'h00;
            wake_reg[0] <= dap_pkg::WAKE_RESET;
            wake_reg[1] <= dap_pkg::WAKE_RESET;
        end
        else
        begin
            stop_cnt_reg <= stop_cnt_next;
            wake_reg[0] <= wake_next[0];
            wake_reg[1] <= wake_next[1];
        end
    end

    assign conv_a_power_en = conv_on[0];
    assign conv_b_power_en = conv_on[1];
    assign ref_power_en = !gpd;
    assign low_power = clk_stopped;
    assign data_drive_level = ctrl_reg.data_drive_level;
    assign clock_drive_level = ctrl_reg.clock_drive_level;
    assign status_word = {25'h0, lvds_on, chan_valid, clk_stopped, mode};

    // ============================================================
    // Output data path
    logic [SAMPLE_W-1:0] cap_a_reg, cap_a_next, cap_b_reg, cap_b_next;
    logic [SAMPLE_W-1:0] a_out_reg, a_out_next, b_out_reg, b_out_next;
    logic [PAIRS-1:0] la_reg, la_next, lb_reg, lb_next;
    logic [PAIRS-1:0] even_a, odd_a, even_b, odd_b;
    logic clk_out_reg;

    // Pair k: bit 2k then bit 2k+1
    for (genvar k = 0; k < PAIRS; k++)
    begin : g_pair
        assign even_a[k] = sync2_reg.a[2*k];
        assign even_b[k] = sync2_reg.b[2*k];
        assign odd_a[k] = cap_a_reg[2*k+1];
        assign odd_b[k] = cap_b_reg[2*k+1];
    end

    // New word on sample rise; odd LVDS phase and mux B half on fall
    always_comb
    begin
        cap_a_next = cap_a_reg;
        cap_b_next = cap_b_reg;
        a_out_next = a_out_reg;
        b_out_next = b_out_reg;
        la_next = la_reg;
        lb_next = lb_reg;
        if (samp_rise)
        begin
            cap_a_next = sync2_reg.a;
            cap_b_next = sync2_reg.b;
            a_out_next = sync2_reg.a;
            b_out_next = mux_on ? sync2_reg.a : sync2_reg.b;
            la_next = even_a;
            lb_next = even_b;
        end
        else if (samp_fall)
        begin
            if (mux_on)
                b_out_next = cap_b_reg;
            la_next = odd_a;
            lb_next = odd_b;
        end
    end

    // Clock out lags data by one cycle so data settles before its edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cap_a_reg <= '0;
            cap_b_reg <= '0;
            a_out_reg <= '0;
            b_out_reg <= '0;
            la_reg <= '0;
            lb_reg <= '0;
            clk_out_reg <= 1'b0;
        end
        else
        begin
            cap_a_reg <= cap_a_next;
            cap_b_reg <= cap_b_next;
            a_out_reg <= a_out_next;
            b_out_reg <= b_out_next;
            la_reg <= la_next;
            lb_reg <= lb_next;
            clk_out_reg <= samp_d_reg;
        end
    end

    assign chan_a_bus_o = a_out_reg;
    assign chan_b_bus_o = b_out_reg;
    assign lvds_a_o = la_reg;
    assign lvds_b_o = lb_reg;
    assign output_clock_single = clk_out_reg;
    assign output_clock_pos = clk_out_reg;
    // Buffers drive only once their wake time is over
    assign chan_a_bus_oe = chan_valid[0] && !lvds_on;
    assign chan_b_bus_oe = chan_valid[1] && !lvds_on;
    assign lvds_a_oe = chan_valid[0] && lvds_on;
    assign lvds_b_oe = chan_valid[1] && lvds_on;
    assign output_clock_single_oe = (|chan_valid) && !lvds_on;
    assign output_clock_pos_oe = (|chan_valid) && lvds_on;

    // ============================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pin_source: assert property (ctrl_reg.pin_config |-> mode == {sync2_reg.mode_pin_msb,
        sync2_reg.mode_pin_mid, sync2_reg.mode_pin_lsb})
        else $error("mode not taken from pins");
    a_off_a_only: assert property (mode == dap_pkg::DAP_OFF_A |->
        !chan_a_bus_oe && !lvds_a_oe && buf_on[1] == !gpd)
        else $error("code 001 wrong buffers");
    a_off_both: assert property (mode == dap_pkg::DAP_OFF_AB |-> !(|buf_on))
        else $error("code 011 left a buffer on");
    a_pwrdn_all: assert property (mode == dap_pkg::DAP_PWRDN |-> !ref_power_en
        && !conv_a_power_en && !conv_b_power_en && !chan_b_bus_oe && !lvds_b_oe)
        else $error("power-down incomplete");
    a_gpd_wake: assert property ($fell(gpd) |-> !(|chan_valid)[*8])
        else $error("data valid too soon after power-down");
    a_standby_a: assert property (mode == dap_pkg::DAP_STBY_A && !clk_stopped |->
        !conv_a_power_en && conv_b_power_en && ref_power_en)
        else $error("standby A wrong");
    a_fast_wake: assert property ($rose(chan_valid[0]) |-> $past(buf_on[0], 5))
        else $error("channel A valid before 100 ns");
    a_mux_hiz: assert property (mux_on |-> !chan_a_bus_oe && !lvds_a_oe)
        else $error("channel A driven in mux mode");
    a_clk_stop: assert property (stop_cnt_reg == dap_pkg::STOP_LIM |-> low_power
        && !ref_power_en && !chan_a_bus_oe && !chan_b_bus_oe)
        else $error("clock stop not detected");
    a_cmos_word: assert property (samp_rise |=> chan_a_bus_o == $past(sync2_reg.a))
        else $error("CMOS word not launched");
    a_lvds_even: assert property (samp_rise |=> lvds_b_o == $past(even_b))
        else $error("even bits not on rising phase");
    a_lvds_odd: assert property (samp_fall |=> lvds_a_o == $past(odd_a))
        else $error("odd bits not on falling phase");
endmodule
`default_nettype wire

/* core/dap_pkg.sv */
// Constants, mode codes and carrier types for the sleep and output port block.
// Assumes a 50 MHz aclk and a sample clock that arrives as an asynchronous pin.
// ============================================================
// Contract
// - Sleep code comes from a register field or three pins; msb pin first, high=1.
// - Code 001 tri-states only channel A buffer, 010 only B; 000 normal.
// - Code 011 tri-states both channel output buffers together.
// - Code 100 powers down both converters, reference and all buffers.
// - Global power-down keeps outputs high-Z; data valid about 15 us after exit.
// - Code 101 stands by converter A, 110 converter B; data back after 100 ns.
// - Code 111 interleaves both channels on the channel B bus.
// - Disabled buffer goes high-Z; data valid again 100 ns after re-enable.
// - Sample clock below 1 MSPS forces low power regardless of the code.
// - Twelve bits per channel plus one shared output clock synchronous to data.
// - CMOS or DDR LVDS chosen by register bit or interface select pin.
// - CMOS mode puts each bit on its own pin, one sample per clock.
// - Separate settings raise CMOS data and CMOS clock drive strength.
// - DDR LVDS pair carries two bits per clock; six pairs per channel.
// - Even bits launch at rising output clock edge, odd bits at falling.
// - Multiplexed mode only with CMOS output standard; below 65 MSPS.
// - Multiplexed mode tri-states all channel A parallel pins.
package dap_pkg;
    // ============================================================
    // Timing
    localparam int CLK_NS = 20;
    localparam int GPD_WAKE_US = 15;
    localparam int FAST_WAKE_NS = 100;
    localparam int MIN_RATE_MSPS = 1;
    localparam int GPD_WAKE_CYC = (GPD_WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int FAST_WAKE_CYC = (FAST_WAKE_NS + CLK_NS - 1) / CLK_NS;
    // Longest allowed sample period, rounded down
    localparam int STOP_CYC = (1000 / MIN_RATE_MSPS) / CLK_NS;
    localparam int WAKE_W = 10;
    localparam logic [WAKE_W-1:0] GPD_WAKE_LD = WAKE_W'(GPD_WAKE_CYC);
    localparam logic [WAKE_W-1:0] FAST_WAKE_LD = WAKE_W'(FAST_WAKE_CYC);
    localparam logic [WAKE_W-1:0] WAKE_RESET = 10'h000;
    localparam logic [7:0] STOP_LIM = 8'(STOP_CYC);
    localparam int SAMPLE_BITS = 12;
    // ============================================================
    // Register map
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam int CTRL_W = 7;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        DAP_NORMAL = 3'b000,
        DAP_OFF_A = 3'b001,
        DAP_OFF_B = 3'b010,
        DAP_OFF_AB = 3'b011,
        DAP_PWRDN = 3'b100,
        DAP_STBY_A = 3'b101,
        DAP_STBY_B = 3'b110,
        DAP_MUX = 3'b111
    } dap_mode_t;
    // Control register, bit 6 down to bit 0
    typedef struct packed {
        logic clock_drive_level;
        logic data_drive_level;
        logic lvds_sel;
        logic pin_config;
        logic [2:0] sleep_code;
    } dap_ctrl_t;
    // Everything that arrives from outside the aclk domain
    typedef struct packed {
        logic samp;
        logic mode_pin_msb;
        logic mode_pin_mid;
        logic mode_pin_lsb;
        logic interface_select_pin;
        logic [SAMPLE_BITS-1:0] a;
        logic [SAMPLE_BITS-1:0] b;
    } dap_pins_t;
endpackage

/* dv/dap_rx_model.sv */
// Receiving logic model: captures CMOS words and rebuilds DDR LVDS words.
// Assumes the output clock is slow against aclk, so its edges are seen.
`timescale 1ns/1ps
`default_nettype none
module dap_rx_model (
    input wire logic aclk,
    input wire logic ck,
    input wire logic [11:0] a_bus,
    input wire logic [11:0] b_bus,
    input wire logic [5:0] la,
    input wire logic [5:0] lb,
    output logic [11:0] cap_a,
    output logic [11:0] cap_b,
    output logic [11:0] wrd_a,
    output logic [11:0] wrd_b
);
    // ============================================================
    // Capture
    logic ck_q;
    logic [5:0] ea;
    logic [5:0] eb;
    // Pair k: bit 2k from the high phase, bit 2k+1 from the low phase
    function automatic logic [11:0] weave(input logic [5:0] e, input logic [5:0] o);
        logic [11:0] w;
        for (int k = 0; k < 6; k++)
        begin
            w[2*k] = e[k];
            w[2*k+1] = o[k];
        end
        return w;
    endfunction
    // Rising edge takes CMOS and even bits, falling edge the odd bits
    always_ff @(posedge aclk)
    begin
        ck_q <= ck;
        if (ck && !ck_q)
        begin
            cap_a <= a_bus;
            cap_b <= b_bus;
            ea <= la;
            eb <= lb;
        end
        if (!ck && ck_q)
        begin
            wrd_a <= weave(ea, la);
            wrd_b <= weave(eb, lb);
        end
    end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the sleep-mode and output port block.
// Assumes an AXI4-Lite register map and a 160 ns sample clock that the last test stops and restarts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ============================================================
    // Signals
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, samp_clk_pin, mode_pin_msb, mode_pin_mid, mode_pin_lsb;
    logic interface_select_pin, chan_a_bus_oe, chan_b_bus_oe, lvds_a_oe, lvds_b_oe;
    logic output_clock_single, data_drive_level, clock_drive_level, low_power;
    logic conv_a_power_en, conv_b_power_en, ref_power_en, samp_run;
    logic output_clock_single_oe, output_clock_pos, output_clock_pos_oe;
    logic [11:0] s_axi_awaddr, s_axi_araddr, conv_a_sample, conv_b_sample, wa, wb;
    logic [11:0] chan_a_bus_o, chan_b_bus_o, cap_a, cap_b, wrd_a, wrd_b;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, e;
    logic [5:0] lvds_a_o, lvds_b_o;
    int errors, tests_run, cyc;
    dap_top #(.SAMPLE_W(12)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .samp_clk_pin, .mode_pin_msb, .mode_pin_mid, .mode_pin_lsb,
        .interface_select_pin, .conv_a_sample, .conv_b_sample, .chan_a_bus_o,
        .chan_a_bus_oe, .chan_b_bus_o, .chan_b_bus_oe, .lvds_a_o, .lvds_a_oe,
        .lvds_b_o, .lvds_b_oe, .output_clock_single, .output_clock_single_oe,
        .output_clock_pos, .output_clock_pos_oe, .data_drive_level,
        .clock_drive_level, .conv_a_power_en, .conv_b_power_en, .ref_power_en,
        .low_power);
    // Released buses read as the inverse, so a missing enable cannot hide
    dap_rx_model rx (.aclk, .ck(output_clock_pos_oe ? output_clock_pos : output_clock_single),
        .a_bus(chan_a_bus_oe ? chan_a_bus_o : ~chan_a_bus_o),
        .b_bus(chan_b_bus_oe ? chan_b_bus_o : ~chan_b_bus_o),
        .la(lvds_a_oe ? lvds_a_o : ~lvds_a_o), .lb(lvds_b_oe ? lvds_b_o : ~lvds_b_o),
        .cap_a, .cap_b, .wrd_a, .wrd_b);
    // ============================================================
    // Clocks: aclk 20 ns, sample clock 160 ns with its own phase
    initial
    begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    initial
    begin
        samp_clk_pin = 0;
        {conv_a_sample, conv_b_sample} = 24'h000000;
        #7;
        forever
        begin
            #80;
            if (samp_run) samp_clk_pin = ~samp_clk_pin;
            if (samp_run && samp_clk_pin) conv_a_sample = wa;
            if (samp_run && samp_clk_pin) conv_b_sample = wb;
        end
    end
    // ============================================================
    // Checks and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, well above the roughly 8600 cycles the tests need
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errors++;
            end_sim();
        end
    end
    // Expected {A, B} drive enables for a sleep code
    function automatic logic [1:0] exp_oe(input logic [2:0] c);
        return {c == 0 || c == 2 || c == 6, c == 0 || c == 1 || c == 5 || c == 7};
    endfunction
    // ============================================================
    // Register bus tasks; each half released once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw, w;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        aw = 0;
        w = 0;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (!aw && s_axi_awready) s_axi_awvalid <= 0;
            if (!w && s_axi_wready) s_axi_wvalid <= 0;
            aw = aw || s_axi_awready;
            w = w || s_axi_wready;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    // ============================================================
    // Main sequence
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
        {s_axi_rready, mode_pin_msb, mode_pin_mid, mode_pin_lsb} = 0;
        {interface_select_pin, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        {errors, tests_run} = 0;
        s_axi_wstrb = 4'hf;
        samp_run = 1;
        wa = $urandom(35);
        wb = 12'h5a3;
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        // Reset value, drive levels, unmapped place
        axi_rd(12'h000, rd, rs);
        chk(rd, 32'h00000000);
        axi_wr(12'h000, 32'h00000060, rs);
        axi_rd(12'h000, rd, rs);
        chk(rd, 32'h00000060);
        chk({data_drive_level, clock_drive_level}, 2'h3);
        axi_rd(12'h008, rd, rs);
        chk(rs, 2'h2);
        chk(rd, 32'h00000000);
        axi_wr(12'h008, 32'h00000007, rs);
        chk(rs, 2'h2);
        $display("Test registers done");
        // Every sleep code through the register
        for (int c = 0; c < 8; c++)
        begin
            wa = $urandom;
            wb = $urandom;
            axi_wr(12'h000, c, rs);
            repeat (900) @(posedge aclk);
            e = exp_oe(c[2:0]);
            chk({chan_a_bus_oe, chan_b_bus_oe}, e);
            chk(output_clock_single_oe, |e);
            chk({ref_power_en, conv_a_power_en}, {c != 4, c != 4 && c != 5});
            chk(conv_b_power_en, c != 4 && c != 6);
            if (e[1]) chk(cap_a, wa);
            if (e[0]) chk(cap_b, c == 7 ? wa : wb);
            $display("Test sleep code %0d done", c);
        end
        // DDR LVDS through the register bit
        axi_wr(12'h000, 32'h00000010, rs);
        repeat (100) @(posedge aclk);
        chk({lvds_a_oe, lvds_b_oe}, 2'h3);
        chk({output_clock_pos_oe, output_clock_single_oe}, 2'h2);
        chk({wrd_a, wrd_b}, {wa, wb});
        $display("Test lvds done");
        // Pin source: msb first, then interface select pin
        axi_wr(12'h000, 32'h00000008, rs);
        mode_pin_msb <= 1;
        mode_pin_mid <= 1;
        repeat (100) @(posedge aclk);
        axi_rd(12'h004, rd, rs);
        chk(rd[2:0], 3'b110);
        chk({chan_a_bus_oe, chan_b_bus_oe}, 2'h2);
        // Mux code under LVDS must leave both channels running
        {mode_pin_msb, mode_pin_mid, mode_pin_lsb} <= 3'h7;
        interface_select_pin <= 1;
        repeat (100) @(posedge aclk);
        chk({lvds_a_oe, lvds_b_oe, wrd_a, wrd_b}, {2'h3, wa, wb});
        $display("Test pins done");
        // Sample clock stopped, then restarted
        samp_run = 0;
        repeat (100) @(posedge aclk);
        chk({low_power, lvds_a_oe, lvds_b_oe}, 3'h4);
        samp_run = 1;
        repeat (900) @(posedge aclk);
        chk({low_power, lvds_a_oe}, 2'h1);
        $display("Test clock stop done");
        end_sim();
    end
endmodule
`default_nettype wire
